// ---- src/gcs_gateway_words.sv ----
`timescale 1ns/1ps
`include "gcs_consts.svh"


module gcs_gateway_words #(
  parameter int AW = `GCS_AREA_AW
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // configuration
  input gcs_pkg::gcs_word_mode_e cfgWordMode,
  input gcs_pkg::gcs_proto_e cfgProto,
  // fieldbus state
  input wire logic fbOnline,
  // fieldbus write into output area
  input wire logic fbWrEn,
  input wire logic [AW-1:0] fbWrAddr,
  input wire logic [7:0] fbWrData,
  // fieldbus read from input area
  input wire logic [AW-1:0] fbRdAddr,
  output logic [7:0] fbRdData,
  // gateway data memory, write side
  output logic memWrEn,
  output logic [AW-1:0] memWrAddr,
  output logic [7:0] memWrData,
  // gateway data memory, read side
  output logic [AW-1:0] memRdAddr,
  input wire logic [7:0] memRdData,
  // subnetwork engine reports
  input wire logic evValid,
  input wire logic [4:0] evCode,
  input wire logic [7:0] evData,
  input wire logic causeClear,
  input wire logic allDoneOnce,
  // subnetwork engine control
  output logic subnetExchEn,
  output logic nodeCmdValid,
  output gcs_pkg::gcs_node_op_e nodeCmdOp,
  output logic [7:0] nodeCmdArg,
  // visible words
  output logic [15:0] statusWord,
  output logic [15:0] controlWord
);

  // reset release
  logic rstMeta_q;
  logic rstSync_q;
  logic rstSync_b;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end

  assign rstSync_b = rstSync_q;

  // configuration decode
  logic wordsOn;
  logic lockOn;
  logic protoQuery;

  always_comb begin
    wordsOn = cfgWordMode != gcs_pkg::GCS_WORD_OFF;
    lockOn = cfgWordMode == gcs_pkg::GCS_WORD_LOCK;
    protoQuery = cfgProto == gcs_pkg::GCS_PROTO_QUERY;
  end

  // byte match within a word slot
  function automatic logic hitByte(
    input logic [AW-1:0] addr,
    input logic [AW-1:0] base,
    input logic lsb
  );
    hitByte = addr == (base | AW'(lsb));
  endfunction

  // control word capture and output forwarding
  logic [15:0] ctrl_q, ctrl_d;
  logic memWrEn_q, memWrEn_d;
  logic [AW-1:0] memWrAddr_q, memWrAddr_d;
  logic [7:0] memWrData_q, memWrData_d;
  logic ctrlHiHit;
  logic ctrlLoHit;

  always_comb begin
    ctrlHiHit = wordsOn && hitByte(fbWrAddr, AW'(`GCS_CONTROL_OFS), 1'b0);
    ctrlLoHit = wordsOn && hitByte(fbWrAddr, AW'(`GCS_CONTROL_OFS), 1'b1);
    ctrl_d = ctrl_q;
    memWrEn_d = 1'b0;
    memWrAddr_d = memWrAddr_q;
    memWrData_d = memWrData_q;
    if (fbWrEn) begin
      if (ctrlHiHit) begin
        ctrl_d[15:8] = fbWrData;
      end else if (ctrlLoHit) begin
        ctrl_d[7:0] = fbWrData;
      end else begin
        memWrEn_d = 1'b1;
        memWrAddr_d = fbWrAddr;
        memWrData_d = fbWrData;
      end
    end
    if (!wordsOn) begin
      ctrl_d = `GCS_WORD_RST;
    end
  end

  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      ctrl_q <= `GCS_WORD_RST;
      memWrEn_q <= 1'b0;
      memWrAddr_q <= '0;
      memWrData_q <= 8'h00;
    end else begin
      ctrl_q <= ctrl_d;
      memWrEn_q <= memWrEn_d;
      memWrAddr_q <= memWrAddr_d;
      memWrData_q <= memWrData_d;
    end
  end

  assign memWrEn = memWrEn_q;
  assign memWrAddr = memWrAddr_q;
  assign memWrData = memWrData_q;
  assign controlWord = ctrl_q;

  // data exchange state machine
  gcs_pkg::gcs_link_e link_q, link_d;
  logic hostDv;

  always_comb begin
    hostDv = ctrl_q[`GCS_CR_DV_BIT];
    link_d = link_q;
    case (link_q)
      gcs_pkg::GCS_ST_OFFLINE: begin
        if (fbOnline) begin
          if (lockOn) begin
            link_d = gcs_pkg::GCS_ST_LOCKED;
          end else begin
            link_d = gcs_pkg::GCS_ST_RUN;
          end
        end
      end
      gcs_pkg::GCS_ST_LOCKED: begin
        if (!fbOnline) begin
          link_d = gcs_pkg::GCS_ST_OFFLINE;
        end else if (!lockOn || hostDv) begin
          link_d = gcs_pkg::GCS_ST_RUN;
        end
      end
      gcs_pkg::GCS_ST_RUN: begin
        if (!fbOnline) begin
          link_d = gcs_pkg::GCS_ST_OFFLINE;
        end else if (lockOn && !hostDv) begin
          link_d = gcs_pkg::GCS_ST_LOCKED;
        end
      end
      default: begin
        link_d = gcs_pkg::GCS_ST_OFFLINE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      link_q <= gcs_pkg::GCS_ST_OFFLINE;
    end else begin
      link_q <= link_d;
    end
  end

  assign subnetExchEn = link_q == gcs_pkg::GCS_ST_RUN;

  // status data-valid
  logic statDv_q, statDv_d;

  always_comb begin
    statDv_d = statDv_q;
    if (!fbOnline || !wordsOn || !protoQuery) begin
      statDv_d = 1'b0;
    end else if (allDoneOnce && subnetExchEn) begin
      statDv_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      statDv_q <= 1'b0;
    end else begin
      statDv_q <= statDv_d;
    end
  end

  // report posting and command handling
  logic postToggle;
  logic ackToggle;
  logic [4:0] repCode;
  logic [7:0] repData;

  gcs_status_post u_post (
    .clk(clk),
    .rstSync_b(rstSync_b),
    .evValid(evValid),
    .evCode(evCode),
    .evData(evData),
    .causeClear(causeClear),
    .protoQuery(protoQuery),
    .hostAck(ctrl_q[`GCS_CR_ACK_BIT]),
    .postToggle_q(postToggle),
    .code_q(repCode),
    .data_q(repData)
  );

  gcs_ctrl_exec u_exec (
    .clk(clk),
    .rstSync_b(rstSync_b),
    .ctrlWord(ctrl_q),
    .protoQuery(protoQuery),
    .ackToggle_q(ackToggle),
    .nodeCmdValid_q(nodeCmdValid),
    .nodeCmdOp_q(nodeCmdOp),
    .nodeCmdArg_q(nodeCmdArg)
  );

  // status word assembly
  always_comb begin
    statusWord = `GCS_WORD_RST;
    if (wordsOn) begin
      statusWord[`GCS_SR_POST_BIT] = postToggle;
      statusWord[`GCS_SR_ACK_BIT] = ackToggle;
      statusWord[`GCS_SR_DV_BIT] = statDv_q;
      statusWord[`GCS_SR_CODE_HI:`GCS_SR_CODE_LO] = repCode;
      statusWord[7:0] = repData;
    end
  end

  // fieldbus read of input area
  logic [7:0] rdData_q, rdData_d;

  assign memRdAddr = fbRdAddr;

  always_comb begin
    rdData_d = memRdData;
    if (wordsOn && hitByte(fbRdAddr, AW'(`GCS_STATUS_OFS), 1'b0)) begin
      rdData_d = statusWord[15:8];
    end else if (wordsOn && hitByte(fbRdAddr, AW'(`GCS_STATUS_OFS), 1'b1)) begin
      rdData_d = statusWord[7:0];
    end
  end

  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      rdData_q <= 8'h00;
    end else begin
      rdData_q <= rdData_d;
    end
  end

  assign fbRdData = rdData_q;

endmodule

// ---- include/gcs_consts.svh ----
`ifndef GCS_CONSTS_SVH
`define GCS_CONSTS_SVH

// fieldbus area addresses, word stored msb first
`define GCS_STATUS_OFS 10'h000
`define GCS_CONTROL_OFS 10'h200
`define GCS_AREA_AW 10

// reset values
`define GCS_WORD_RST 16'h0000

// status word fields
`define GCS_SR_POST_BIT 15
`define GCS_SR_ACK_BIT 14
`define GCS_SR_DV_BIT 13
`define GCS_SR_CODE_HI 12
`define GCS_SR_CODE_LO 8

// control word fields
`define GCS_CR_ACK_BIT 15
`define GCS_CR_POST_BIT 14
`define GCS_CR_DV_BIT 13
`define GCS_CR_EXEC_BIT 12
`define GCS_CR_CODE_HI 11
`define GCS_CR_CODE_LO 8

// status codes, query-response modes
`define GCS_SC_RETRY 5'h00
`define GCS_SC_MISS_ONE 5'h01
`define GCS_SC_MISS_MANY 5'h02
`define GCS_SC_OVERRUN 5'h03
`define GCS_SC_OTHER 5'h04
`define GCS_SC_NO_ERR 5'h1f

// control codes, query-response modes
`define GCS_CC_DISABLE 4'h0
`define GCS_CC_ENABLE 4'h1
`define GCS_CC_FIRST_N 4'h2

`endif

// ---- include/gcs_pkg.sv ----
package gcs_pkg;

  typedef enum logic [1:0] {
    GCS_WORD_OFF,
    GCS_WORD_LOCK,
    GCS_WORD_NOLOCK
  } gcs_word_mode_e;

  typedef enum logic {
    GCS_PROTO_QUERY,
    GCS_PROTO_UNSOL
  } gcs_proto_e;

  typedef enum logic [1:0] {
    GCS_ST_OFFLINE,
    GCS_ST_LOCKED,
    GCS_ST_RUN
  } gcs_link_e;

  typedef enum logic [1:0] {
    GCS_NODE_DISABLE,
    GCS_NODE_ENABLE,
    GCS_NODE_FIRST_N
  } gcs_node_op_e;

endpackage

// ---- src/gcs_status_post.sv ----
`timescale 1ns/1ps
`include "gcs_consts.svh"

module gcs_status_post (
  // clock and reset
  input wire logic clk,
  input wire logic rstSync_b,
  // report source
  input wire logic evValid,
  input wire logic [4:0] evCode,
  input wire logic [7:0] evData,
  input wire logic causeClear,
  input wire logic protoQuery,
  // handshake
  input wire logic hostAck,
  output logic postToggle_q,
  output logic [4:0] code_q,
  output logic [7:0] data_q
);

  logic pendValid_q, pendValid_d;
  logic [4:0] pendCode_q, pendCode_d;
  logic [7:0] pendData_q, pendData_d;
  logic errOpen_q, errOpen_d;
  logic postToggle_d;
  logic [4:0] code_d;
  logic [7:0] data_d;
  logic canPost;

  function automatic logic isError(input logic [4:0] c);
    isError = (c == `GCS_SC_MISS_ONE) || (c == `GCS_SC_MISS_MANY) ||
              (c == `GCS_SC_OTHER);
  endfunction

  always_comb begin
    canPost = pendValid_q && (hostAck == postToggle_q);
    pendValid_d = pendValid_q;
    pendCode_d = pendCode_q;
    pendData_d = pendData_q;
    errOpen_d = errOpen_q;
    postToggle_d = postToggle_q;
    code_d = code_q;
    data_d = data_q;
    if (canPost) begin
      postToggle_d = ~postToggle_q;
      code_d = pendCode_q;
      data_d = pendData_q;
      pendValid_d = 1'b0;
    end
    if (evValid) begin
      pendValid_d = 1'b1;
      pendCode_d = evCode;
      pendData_d = evData;
      if (protoQuery && isError(evCode)) begin
        errOpen_d = 1'b1;
      end
    end else if (causeClear && errOpen_q) begin
      pendValid_d = 1'b1;
      pendCode_d = `GCS_SC_NO_ERR;
      pendData_d = 8'h00;
      errOpen_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      pendValid_q <= 1'b0;
      pendCode_q <= 5'h00;
      pendData_q <= 8'h00;
      errOpen_q <= 1'b0;
      postToggle_q <= 1'b0;
      code_q <= `GCS_SC_NO_ERR;
      data_q <= 8'h00;
    end else begin
      pendValid_q <= pendValid_d;
      pendCode_q <= pendCode_d;
      pendData_q <= pendData_d;
      errOpen_q <= errOpen_d;
      postToggle_q <= postToggle_d;
      code_q <= code_d;
      data_q <= data_d;
    end
  end

endmodule

// ---- src/gcs_ctrl_exec.sv ----
`timescale 1ns/1ps
`include "gcs_consts.svh"

module gcs_ctrl_exec (
  // clock and reset
  input wire logic clk,
  input wire logic rstSync_b,
  // control word
  input wire logic [15:0] ctrlWord,
  input wire logic protoQuery,
  // handshake back to host
  output logic ackToggle_q,
  // node command out
  output logic nodeCmdValid_q,
  output gcs_pkg::gcs_node_op_e nodeCmdOp_q,
  output logic [7:0] nodeCmdArg_q
);

  logic ackToggle_d;
  logic nodeCmdValid_d;
  gcs_pkg::gcs_node_op_e nodeCmdOp_d;
  logic [7:0] nodeCmdArg_d;
  logic newPost;
  logic [3:0] ccode;

  always_comb begin
    newPost = ctrlWord[`GCS_CR_POST_BIT] != ackToggle_q;
    ccode = ctrlWord[`GCS_CR_CODE_HI:`GCS_CR_CODE_LO];
    ackToggle_d = ackToggle_q;
    nodeCmdValid_d = 1'b0;
    nodeCmdOp_d = nodeCmdOp_q;
    nodeCmdArg_d = nodeCmdArg_q;
    if (newPost) begin
      ackToggle_d = ctrlWord[`GCS_CR_POST_BIT];
      if (protoQuery && ctrlWord[`GCS_CR_EXEC_BIT]) begin
        nodeCmdArg_d = ctrlWord[7:0];
        if (ccode == `GCS_CC_DISABLE) begin
          nodeCmdValid_d = 1'b1;
          nodeCmdOp_d = gcs_pkg::GCS_NODE_DISABLE;
        end else if (ccode == `GCS_CC_ENABLE) begin
          nodeCmdValid_d = 1'b1;
          nodeCmdOp_d = gcs_pkg::GCS_NODE_ENABLE;
        end else if (ccode == `GCS_CC_FIRST_N) begin
          nodeCmdValid_d = 1'b1;
          nodeCmdOp_d = gcs_pkg::GCS_NODE_FIRST_N;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      ackToggle_q <= 1'b0;
      nodeCmdValid_q <= 1'b0;
      nodeCmdOp_q <= gcs_pkg::GCS_NODE_DISABLE;
      nodeCmdArg_q <= 8'h00;
    end else begin
      ackToggle_q <= ackToggle_d;
      nodeCmdValid_q <= nodeCmdValid_d;
      nodeCmdOp_q <= nodeCmdOp_d;
      nodeCmdArg_q <= nodeCmdArg_d;
    end
  end

endmodule

// ---- verif/gcs_gateway_words_monitor.sv ----
`timescale 1ns/1ps
module gcs_gateway_words_monitor #(
  parameter int AW = 10
) (
  // clock and reset
  input logic clk,
  input logic rst_b,
  // configuration and fieldbus
  input gcs_pkg::gcs_word_mode_e cfgWordMode,
  input gcs_pkg::gcs_proto_e cfgProto,
  input logic fbOnline,
  input logic fbWrEn,
  input logic [AW-1:0] fbWrAddr,
  input logic [7:0] fbWrData,
  input logic [AW-1:0] fbRdAddr,
  input logic [7:0] fbRdData,
  // memory
  input logic memWrEn,
  input logic [AW-1:0] memWrAddr,
  input logic [7:0] memWrData,
  input logic [7:0] memRdData,
  // engine and words
  input logic allDoneOnce,
  input logic subnetExchEn,
  input logic nodeCmdValid,
  input logic [15:0] statusWord,
  input logic [15:0] controlWord
);
  logic on;
  logic lock;
  assign on = cfgWordMode != gcs_pkg::GCS_WORD_OFF;
  assign lock = cfgWordMode == gcs_pkg::GCS_WORD_LOCK;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_off_zero: assert property (!on [*3] |-> statusWord == 16'h0000 && controlWord == 16'h0000)
    else $error("words visible while disabled");
  a_mem_write: assert property (!on && fbWrEn && $past(rst_b, 3) |=> memWrEn
    && memWrAddr == $past(fbWrAddr) && memWrData == $past(fbWrData))
    else $error("write not forwarded");
  a_mem_read: assert property (!on && $past(rst_b, 3) |=> fbRdData == $past(memRdData))
    else $error("read not from memory");
  a_read_msb: assert property (on && fbRdAddr == '0 && $past(rst_b, 3)
    |=> fbRdData == $past(statusWord[15:8]))
    else $error("status high byte not first");
  a_exch_free: assert property ((!lock && fbOnline) [*4] |-> subnetExchEn)
    else $error("exchange not started");
  a_lock_hold: assert property ((lock && !controlWord[13]) [*2] |-> !subnetExchEn)
    else $error("exchange without data valid");
  a_dv_sticky: assert property (statusWord[13] && fbOnline && cfgProto == gcs_pkg::GCS_PROTO_QUERY
    |=> statusWord[13] || !on)
    else $error("data valid dropped");
  a_dv_cause: assert property ($rose(statusWord[13]) |-> $past(allDoneOnce) && $past(subnetExchEn))
    else $error("data valid without cause");
  a_post_gate: assert property ($changed(statusWord[15]) && on && $past(on)
    |-> $past(controlWord[15]) == $past(statusWord[15]))
    else $error("post before confirm");
  a_ack_copy: assert property ($changed(controlWord[14]) && on
    |-> ##[1:4] statusWord[14] == controlWord[14])
    else $error("host post not confirmed");
  a_cmd_pulse: assert property (nodeCmdValid |-> controlWord[12] ##1 !nodeCmdValid)
    else $error("bad command pulse");
  c_post: cover property ($changed(statusWord[15]));
  c_cmd: cover property (nodeCmdValid);
  c_dv: cover property ($rose(statusWord[13]));
endmodule

bind gcs_gateway_words gcs_gateway_words_monitor #(.AW(AW)) gcs_gateway_words_monitor_i (.*);

// ---- verif/gcs_host_model.sv ----
`timescale 1ns/1ps
module gcs_host_model (
  // clock and controls
  input logic clk,
  input logic online,
  input logic dvAllow,
  input logic autoAck,
  // command request
  input logic cmdReq,
  input logic [3:0] cmdCode,
  input logic [7:0] cmdArg,
  // gateway side
  input logic [15:0] statusWord,
  output logic fbWrEn,
  output logic [9:0] fbWrAddr,
  output logic [7:0] fbWrData
);
  logic [15:0] shadow = 16'h0000;
  logic [15:0] sent = 16'h0000;
  logic phase = 1'b0;
  initial begin
    fbWrEn = 1'b0;
    fbWrAddr = 10'h000;
    fbWrData = 8'h00;
  end
  always @(negedge clk) begin
    if (!online || !dvAllow) shadow[13] = 1'b0;
    else if (!statusWord[13]) shadow[13] = 1'b1;
    if (autoAck) shadow[15] = statusWord[15];
    if (cmdReq && shadow[14] == statusWord[14]) begin
      shadow[14] = ~shadow[14];
      shadow[12:0] = {1'b1, cmdCode, cmdArg};
    end
    // low byte first so the send bit lands last
    fbWrEn = 1'b0;
    fbWrData = ~fbWrData;
    if (phase) begin
      {fbWrEn, fbWrAddr, fbWrData} = {1'b1, 10'h200, sent[15:8]};
      phase = 1'b0;
    end else if (shadow != sent) begin
      sent = shadow;
      {fbWrEn, fbWrAddr, fbWrData} = {1'b1, 10'h201, sent[7:0]};
      phase = 1'b1;
    end
  end
endmodule

// ---- verif/gcs_gateway_words_tb.sv ----
`timescale 1ns/1ps
module gcs_gateway_words_tb;
  logic clk, rst_b, fbOnline, evValid, causeClear, allDoneOnce, dvAllow, autoAck, cmdReq;
  logic fbWrEn, memWrEn, subnetExchEn, nodeCmdValid, tog, cmdTog;
  logic [9:0] fbWrAddr, fbRdAddr, memWrAddr, memRdAddr;
  logic [7:0] fbWrData, fbRdData, memWrData, memRdData, evData, cmdArg, nodeCmdArg;
  logic [4:0] evCode;
  logic [3:0] cmdCode;
  logic [15:0] statusWord, controlWord;
  gcs_pkg::gcs_word_mode_e mode;
  gcs_pkg::gcs_proto_e proto;
  gcs_pkg::gcs_node_op_e nodeCmdOp;
  int errTotal, samplesChecked, cycles, n;
  // kind (0 report, 1 clear, 2 ignored clear), code, data, expected code and data
  logic [35:0] rows [8] = '{36'h0_00_03_00_03, 36'h0_01_12_01_12, 36'h1_00_00_1f_00,
    36'h0_03_34_03_34, 36'h2_00_00_03_34, 36'h0_02_05_02_05, 36'h0_04_21_04_21, 36'h1_00_00_1f_00};

  assign memRdData = ~memRdAddr[7:0];

  gcs_gateway_words #(.AW(10)) gcs_gateway_words_i (.clk, .rst_b, .cfgWordMode(mode),
    .cfgProto(proto), .fbOnline, .fbWrEn, .fbWrAddr, .fbWrData, .fbRdAddr,
    .fbRdData, .memWrEn, .memWrAddr, .memWrData, .memRdAddr, .memRdData, .evValid, .evCode,
    .evData, .causeClear, .allDoneOnce, .subnetExchEn, .nodeCmdValid, .nodeCmdOp, .nodeCmdArg,
    .statusWord, .controlWord);

  gcs_host_model gcs_host_model_i (.clk, .online(fbOnline), .dvAllow, .autoAck, .cmdReq,
    .cmdCode, .cmdArg, .statusWord, .fbWrEn, .fbWrAddr, .fbWrData);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      errTotal++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic ev(input logic clr, input logic [4:0] c, input logic [7:0] d);
    {evValid, causeClear, evCode, evData} = {!clr, clr, c, d};
    cyc(1);
    {evValid, causeClear} = 2'b00;
  endtask

  task automatic endOfTest;
    $display("checks=%0d errors=%0d", samplesChecked, errTotal);
    if (errTotal == 0 && samplesChecked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles > 6000) begin
      errTotal++;
      endOfTest();
    end
  end

  initial begin
    {rst_b, fbOnline, evValid, causeClear, allDoneOnce, dvAllow, cmdReq, tog, cmdTog} = '0;
    {evCode, evData, cmdCode, cmdArg, fbRdAddr} = '0;
    autoAck = 1'b1;
    mode = gcs_pkg::GCS_WORD_LOCK;
    proto = gcs_pkg::GCS_PROTO_QUERY;
    cyc(8);
    rst_b = 1'b1;
    cyc(3);
    chk(statusWord, 16'h1f00);
    fbOnline = 1'b1;
    cyc(10);
    chk(subnetExchEn, 1'b0);
    dvAllow = 1'b1;
    cyc(8);
    chk(subnetExchEn, 1'b1);
    foreach (rows[i]) begin
      ev(rows[i][35:32] != 4'h0, rows[i][28:24], rows[i][23:16]);
      tog ^= rows[i][35:32] != 4'h2;
      cyc(8);
      chk(statusWord[12:0], rows[i][12:0]);
      chk(statusWord[15], tog);
    end
    // host stalls its confirm: second report must wait
    autoAck = 1'b0;
    ev(1'b0, 5'h01, 8'h44);
    ev(1'b0, 5'h03, 8'h66);
    tog = ~tog;
    cyc(6);
    chk(statusWord[12:0], 13'h0144);
    autoAck = 1'b1;
    tog = ~tog;
    cyc(12);
    chk(statusWord[12:0], 13'h0366);
    chk(controlWord[15], tog);
    cyc(1);
    chk(fbRdData, {tog, 7'h03});
    fbRdAddr = 10'h001;
    cyc(1);
    chk(fbRdData, 8'h66);
    for (int k = 0; k < 3; k++) begin
      cmdCode = k[3:0];
      cmdArg = 8'h20 + k[7:0];
      cmdReq = 1'b1;
      cyc(2);
      cmdReq = 1'b0;
      cmdTog = ~cmdTog;
      n = 0;
      while (nodeCmdValid !== 1'b1 && n < 20) begin
        @(posedge clk);
        #1;
        n++;
      end
      chk(nodeCmdOp, k[15:0]);
      chk(nodeCmdArg, cmdArg);
      cyc(6);
      chk(statusWord[14], cmdTog);
    end
    allDoneOnce = 1'b1;
    cyc(3);
    allDoneOnce = 1'b0;
    cyc(3);
    chk(statusWord[13], 1'b1);
    fbOnline = 1'b0;
    cyc(3);
    chk(subnetExchEn, 1'b0);
    mode = gcs_pkg::GCS_WORD_OFF;
    fbRdAddr = 10'h000;
    cyc(3);
    chk(statusWord, 16'h0000);
    chk(fbRdData, 8'hff);
    for (int k = 0; k < 2; k++) begin
      if (k == 1) mode = gcs_pkg::GCS_WORD_NOLOCK;
      dvAllow = 1'b0;
      fbOnline = 1'b1;
      cyc(4);
      chk(subnetExchEn, 1'b1);
      fbOnline = 1'b0;
      cyc(3);
    end
    // unsolicited mode: data-valid bit stays unused
    proto = gcs_pkg::GCS_PROTO_UNSOL;
    fbOnline = 1'b1;
    allDoneOnce = 1'b1;
    cyc(4);
    chk(subnetExchEn, 1'b1);
    chk(statusWord[13], 1'b0);
    allDoneOnce = 1'b0;
    fbOnline = 1'b0;
    cyc(3);
    endOfTest();
  end
endmodule
